//--- core/rkc_pkg.sv
// ============================================================
// Shared constants and types for the repeater key control
package rkc_pkg;

  // ============================================================
  // Clock and timing
  localparam int unsigned RKC_CLK_HZ          = 25_000_000;
  localparam int unsigned RKC_HANG_STEP_MS    = 250;         // One hang step, 0.25 s
  localparam int unsigned RKC_HANG_MAX_MS     = 3750;        // Longest hang time
  localparam int unsigned RKC_HANG_MAX_STEPS  = RKC_HANG_MAX_MS / RKC_HANG_STEP_MS;
  localparam int unsigned RKC_HANG_STEP_CYCLES = (RKC_CLK_HZ / 1000) * RKC_HANG_STEP_MS;
  localparam int unsigned RKC_BURST_MS        = 100;         // Length of the noise burst
  localparam int unsigned RKC_BURST_CYCLES    = (RKC_CLK_HZ / 1000) * RKC_BURST_MS;
  localparam int unsigned RKC_CNT_W           = 23;          // Wide enough for both counts

  // ============================================================
  // Bus and register map
  localparam int unsigned RKC_ADDR_W   = 4;
  localparam int unsigned RKC_DATA_W   = 32;
  localparam logic [3:0]  RKC_OFF_CTRL   = 4'h0;   // Hang steps, read/write
  localparam logic [3:0]  RKC_OFF_MODE   = 4'h4;   // Per-channel modulation, read/write
  localparam logic [3:0]  RKC_OFF_STATUS = 4'h8;   // Live state, read only

  // CTRL fields
  localparam int unsigned RKC_CTRL_HANG_LSB = 0;
  localparam int unsigned RKC_HANG_W        = 4;
  localparam logic [3:0]  RKC_CTRL_RST      = 4'h0;

  // MODE: bit i is bank A channel i, bit 16+i is bank B channel i; 1 means digital
  localparam logic [31:0] RKC_MODE_RST = 32'hffff0000;

  // STATUS fields
  localparam int unsigned RKC_ST_KEY     = 0;
  localparam int unsigned RKC_ST_BANKB   = 1;
  localparam int unsigned RKC_ST_DIGITAL = 2;
  localparam int unsigned RKC_ST_BURST   = 3;
  localparam int unsigned RKC_ST_CHAN_LSB = 4;
  localparam int unsigned RKC_ST_STATE_LSB = 8;
  localparam int unsigned RKC_ST_CAR_A   = 10;
  localparam int unsigned RKC_ST_CAR_B   = 11;
  localparam int unsigned RKC_ST_JUMPER  = 12;

  // ============================================================
  // Synchroniser reset value: carriers idle high, jumper open, channel 0
  localparam logic [6:0] RKC_SYNC_RST = 7'h03;

  // ============================================================
  // Types
  typedef enum logic [1:0] {
    RKC_IDLE  = 2'b00,
    RKC_KEYED = 2'b01,
    RKC_HANG  = 2'b11,
    RKC_BURST = 2'b10
  } rkc_state_t;

  typedef struct packed {
    logic       key;          // Transmitter keyed
    logic       bankB;        // 0 bank A, 1 bank B
    logic       digitalMod;   // Modulation of the chosen channel
    logic [3:0] channel;      // Index within the bank
  } rkc_tx_ctl_t;

endpackage

//--- core/rkc_sync.sv
`timescale 1ns/1ps
// ============================================================
// Two-stage synchroniser for asynchronous pin inputs
module rkc_sync
  import rkc_pkg::*;
#(
  parameter int unsigned   W       = 7,
  parameter logic [W-1:0]  RST_VAL = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage1  <= RST_VAL;
      syncOut <= RST_VAL;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule

//--- core/rkc_key_control.sv
`timescale 1ns/1ps
// Behaviour
// - Four select inputs pick channel; grounded is first
// - Modulation follows the chosen channel's mode
// - Hang timer holds key, 0 to 3.75 s
// - Lamps show keyed bank, not modulation
// - Noise burst at end, jumper suppresses it
module rkc_key_control
  import rkc_pkg::*;
#(
  parameter logic [RKC_CNT_W-1:0] HANG_TICK_CYCLES = RKC_CNT_W'(RKC_HANG_STEP_CYCLES),
  parameter logic [RKC_CNT_W-1:0] BURST_CYCLES     = RKC_CNT_W'(RKC_BURST_CYCLES)
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  analog_carrier_detect_n,
  input  wire logic                  digital_carrier_detect_n,
  input  wire logic [3:0]            channel_index_in,
  input  wire logic                  burstDisableJumper,
  input  wire logic [RKC_ADDR_W-1:0] regAddr,
  input  wire logic [RKC_DATA_W-1:0] regWrData,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output rkc_tx_ctl_t                txCtl,
  output logic                       lampBankA,
  output logic                       lampBankB,
  output logic                       noiseBurst,
  output logic [RKC_DATA_W-1:0]      regRdData
);

  // ============================================================
  // Pin synchronisation
  logic [6:0]            syncBits;
  logic                  carA;
  logic                  carB;
  logic                  carAny;
  logic                  jumperSet;
  logic [3:0]            chanSync;

  // Carriers, jumper and channel lines all come from pins
  rkc_sync #(
    .W       (7),
    .RST_VAL (RKC_SYNC_RST)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .asyncIn ({channel_index_in, burstDisableJumper,
               digital_carrier_detect_n, analog_carrier_detect_n}),
    .syncOut (syncBits)
  );

  // Active-low carriers turned to active-high
  assign carA      = ~syncBits[0];
  assign carB      = ~syncBits[1];
  assign carAny    = carA | carB;
  assign jumperSet = syncBits[2];
  assign chanSync  = syncBits[6:3];

  // ============================================================
  // Registers
  logic [RKC_HANG_W-1:0] hangSteps;
  logic [31:0]           modeBits;

  // Software writes of hang time and channel modes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hangSteps <= RKC_CTRL_RST;
      modeBits  <= RKC_MODE_RST;
    end else if (regWr) begin
      if (regAddr == RKC_OFF_CTRL) begin
        hangSteps <= regWrData[RKC_CTRL_HANG_LSB +: RKC_HANG_W];
      end
      if (regAddr == RKC_OFF_MODE) begin
        modeBits <= regWrData;
      end
    end
  end

  // ============================================================
  // Key state machine
  rkc_state_t            state;
  rkc_state_t            next_state;
  logic                  bankB;
  logic [3:0]            chanReg;
  logic [RKC_CNT_W-1:0]  tickCnt;
  logic                  tick;
  logic [RKC_HANG_W:0]   hangCnt;
  logic                  hangDone;
  logic [RKC_CNT_W-1:0]  burstCnt;
  logic                  burstDone;
  logic                  modeSel;

  assign tick      = (tickCnt == HANG_TICK_CYCLES - RKC_CNT_W'(1));
  assign hangDone  = tick && ((hangCnt + 5'h01) >= {1'b0, hangSteps});
  assign burstDone = (burstCnt == BURST_CYCLES - RKC_CNT_W'(1));
  assign modeSel   = modeBits[{bankB, chanReg}];

  // Next state from carriers, hang timer and burst timer
  always_comb begin
    next_state = state;
    unique case (state)
      RKC_IDLE: begin
        if (carAny) begin
          next_state = RKC_KEYED;
        end
      end
      RKC_KEYED: begin
        if (!carAny) begin
          if (hangSteps != '0) begin
            next_state = RKC_HANG;
          end else if (!jumperSet) begin
            next_state = RKC_BURST;
          end else begin
            next_state = RKC_IDLE;
          end
        end
      end
      RKC_HANG: begin
        if (carAny) begin
          next_state = RKC_KEYED;
        end else if (hangDone) begin
          next_state = jumperSet ? RKC_IDLE : RKC_BURST;
        end
      end
      RKC_BURST: begin
        if (carAny) begin
          next_state = RKC_KEYED;
        end else if (burstDone) begin
          next_state = RKC_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= RKC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Bank follows the active carrier; analog wins if both
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bankB <= 1'b0;
    end else if (carA) begin
      bankB <= 1'b0;
    end else if (carB) begin
      bankB <= 1'b1;
    end
  end

  // Channel index tracks the select lines
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chanReg <= 4'h0;
    end else begin
      chanReg <= chanSync;
    end
  end

  // Quarter-second divider and step counter, only while hanging
  always_ff @(posedge ref_clk) begin
    if (rst || state != RKC_HANG) begin
      tickCnt <= '0;
      hangCnt <= '0;
    end else if (tick) begin
      tickCnt <= '0;
      hangCnt <= hangCnt + 5'h01;
    end else begin
      tickCnt <= tickCnt + RKC_CNT_W'(1);
    end
  end

  // Burst length counter
  always_ff @(posedge ref_clk) begin
    if (rst || state != RKC_BURST) begin
      burstCnt <= '0;
    end else begin
      burstCnt <= burstCnt + RKC_CNT_W'(1);
    end
  end

  // ============================================================
  // Registered outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txCtl      <= '0;
      lampBankA  <= 1'b0;
      lampBankB  <= 1'b0;
      noiseBurst <= 1'b0;
    end else begin
      txCtl.key        <= (state != RKC_IDLE);
      txCtl.bankB      <= bankB;
      txCtl.digitalMod <= modeSel;
      txCtl.channel    <= chanReg;
      lampBankA        <= (state != RKC_IDLE) && !bankB;
      lampBankB        <= (state != RKC_IDLE) && bankB;
      noiseBurst       <= (state == RKC_BURST);
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst || !regRd) begin
      regRdData <= '0;
    end else begin
      regRdData <= '0;
      unique case (regAddr)
        RKC_OFF_CTRL:   regRdData[RKC_CTRL_HANG_LSB +: RKC_HANG_W] <= hangSteps;
        RKC_OFF_MODE:   regRdData <= modeBits;
        RKC_OFF_STATUS: begin
          regRdData[RKC_ST_KEY]                <= txCtl.key;
          regRdData[RKC_ST_BANKB]              <= txCtl.bankB;
          regRdData[RKC_ST_DIGITAL]            <= txCtl.digitalMod;
          regRdData[RKC_ST_BURST]              <= noiseBurst;
          regRdData[RKC_ST_CHAN_LSB +: 4]      <= txCtl.channel;
          regRdData[RKC_ST_STATE_LSB +: 2]     <= state;
          regRdData[RKC_ST_CAR_A]              <= carA;
          regRdData[RKC_ST_CAR_B]              <= carB;
          regRdData[RKC_ST_JUMPER]             <= jumperSet;
        end
        default: regRdData <= '0;
      endcase
    end
  end

  // ============================================================
  // Assertions
  // All checks run on the one clock and rest during reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Bank, channel and modulation choice
  a_bank_a_key: assert property (carA |-> ##2 (txCtl.key && !txCtl.bankB))
    else $error("analog carrier did not key bank A");

  a_bank_b_key: assert property ((carB && !carA) |-> ##2 (txCtl.key && txCtl.bankB))
    else $error("digital carrier did not key bank B");

  a_chan_track: assert property (##2 (txCtl.channel == $past(chanSync, 2)))
    else $error("channel output does not follow select lines");

  a_mode_follow: assert property (txCtl.key |-> txCtl.digitalMod == $past(modeSel))
    else $error("modulation does not follow channel mode");

  a_first_chan: assert property ((chanSync == 4'h0) |-> ##2 (txCtl.channel == 4'h0))
    else $error("grounded select lines did not give first channel");

  // Hang timer
  a_hang_enter: assert property ((state == RKC_KEYED && !carAny && hangSteps != '0)
                                 |=> state == RKC_HANG)
    else $error("hang not entered after carrier drop");

  a_hang_bound: assert property (state == RKC_HANG |-> hangCnt < 5'(RKC_HANG_MAX_STEPS))
    else $error("hang counter passed its longest value");

  a_hang_hold: assert property ((state == RKC_HANG && !carAny && !hangDone)
                                |=> state == RKC_HANG ##1 txCtl.key)
    else $error("key dropped before hang time ended");

  // Lamps
  a_lamp_bank: assert property ((lampBankA == (txCtl.key && !txCtl.bankB)) &&
                                (lampBankB == (txCtl.key && txCtl.bankB)))
    else $error("lamps disagree with keyed bank");

  a_lamp_excl: assert property (!(lampBankA && lampBankB))
    else $error("both lamps lit");

  // End burst
  a_burst_supp: assert property ((jumperSet && state != RKC_BURST) |=> state != RKC_BURST)
    else $error("burst entered with jumper set");

  a_burst_len: assert property ((state == RKC_BURST && !carAny && burstDone)
                                |=> state == RKC_IDLE ##1 !noiseBurst)
    else $error("burst did not end on time");

  a_zero_hang: assert property ((state == RKC_KEYED && !carAny && !jumperSet &&
                                 hangSteps == '0) |=> state == RKC_BURST)
    else $error("burst skipped with no hang time");

  a_burst_keyed: assert property (noiseBurst |-> txCtl.key)
    else $error("key dropped during burst");

  // Keying
  a_key_cause: assert property ((state == RKC_IDLE && !carAny) |=> state == RKC_IDLE)
    else $error("keyed without an active carrier");

  a_rekey_hang: assert property ((state == RKC_HANG && carAny) |=> state == RKC_KEYED)
    else $error("carrier during hang did not re-key");

  a_dekey_idle: assert property ((state == RKC_IDLE) |=> !txCtl.key)
    else $error("key held while idle");

  // Main scenarios
  c_key_bank_a: cover property (carA ##2 lampBankA);
  c_key_bank_b: cover property ((carB && !carA) ##2 lampBankB);
  c_hang_rekey: cover property (state == RKC_HANG ##1 state == RKC_KEYED);
  c_burst_done: cover property (state == RKC_BURST ##1 state == RKC_IDLE);
  c_zero_hang:  cover property (state == RKC_KEYED ##1 state == RKC_BURST);

endmodule

//--- test/rkc_rx_model.sv
`timescale 1ns/1ps
// ============================================================
// Receiver model driving the two carrier lines
module rkc_rx_model (
  input  wire logic       ref_clk,
  input  wire logic [1:0] rxCmd,
  output logic            analog_carrier_detect_n,
  output logic            digital_carrier_detect_n
);
  // Idle lines high from time zero, then one line per signal class
  initial begin
    analog_carrier_detect_n  = 1'b1;
    digital_carrier_detect_n = 1'b1;
    forever begin
      @(posedge ref_clk);
      // At most one line, analog taken if both are asked for
      analog_carrier_detect_n  <= !rxCmd[0];
      digital_carrier_detect_n <= !(rxCmd[1] && !rxCmd[0]);
    end
  end
endmodule

//--- test/repeater_key_control_tb.sv
`timescale 1ns/1ps
// ============================================================
// Self-checking bench for the repeater key control
module repeater_key_control_tb;
  import rkc_pkg::*;
  localparam int HT = 8;  // Shortened hang step
  localparam int BT = 5;  // Shortened burst
  logic                  ref_clk, rst, jumper, regWr, regRd, carA_n, carB_n;
  logic                  lampBankA, lampBankB, noiseBurst;
  logic [1:0]            rxCmd;
  logic [3:0]            chanPins;
  logic [RKC_ADDR_W-1:0] regAddr;
  logic [RKC_DATA_W-1:0] regWrData, regRdData, rdv;
  rkc_tx_ctl_t           txCtl;
  int                    err_count, n_compared, cycles;

  rkc_rx_model rx (.ref_clk(ref_clk), .rxCmd(rxCmd), .analog_carrier_detect_n(carA_n),
    .digital_carrier_detect_n(carB_n));
  rkc_key_control #(.HANG_TICK_CYCLES(RKC_CNT_W'(HT)), .BURST_CYCLES(RKC_CNT_W'(BT))) dut (
    .ref_clk(ref_clk), .rst(rst), .analog_carrier_detect_n(carA_n),
    .digital_carrier_detect_n(carB_n), .channel_index_in(chanPins),
    .burstDisableJumper(jumper), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .txCtl(txCtl), .lampBankA(lampBankA), .lampBankB(lampBankB),
    .noiseBurst(noiseBurst), .regRdData(regRdData));

  // ============================================================
  // Clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      finish_test();
    end
  end

  // ============================================================
  // Shared tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask
  // Wait for key to drop or burst to start, counting cycles
  task automatic wait_end(output int c);
    c = 0;
    while (txCtl.key === 1'b1 && noiseBurst !== 1'b1 && c < 200) begin
      @(posedge ref_clk);
      #1 c++;
    end
  endtask

  // ============================================================
  // Scenarios
  task automatic t_key(input logic [1:0] cmd, input logic [3:0] ch, input logic [31:0] mode);
    logic        b;
    logic [31:0] st;
    int          c;
    b = (cmd == 2'd2);
    @(posedge ref_clk);
    chanPins <= ch;
    rxCmd    <= cmd;
    repeat (6) @(posedge ref_clk);
    #1;
    chk("key", txCtl.key, 1);
    chk("bankB", txCtl.bankB, b);
    chk("channel", txCtl.channel, ch);
    chk("digitalMod", txCtl.digitalMod, mode[{b, ch}]);
    chk("lamps", {lampBankB, lampBankA}, {b, !b});
    reg_rd(RKC_OFF_STATUS, st);
    chk("status", st[7:0], {ch, 1'b0, mode[{b, ch}], b, 1'b1});
    chk("statusCar", st[RKC_ST_CAR_B:RKC_ST_CAR_A], {b, !b});
    @(posedge ref_clk);
    rxCmd <= 2'd0;
    // Wait through any hang and burst until the key drops
    c = 0;
    while (txCtl.key === 1'b1 && c < 300) begin
      @(posedge ref_clk);
      #1 c++;
    end
    chk("dekeyed", txCtl.key, 0);
  endtask
  task automatic t_hang(input int n, input logic jmp);
    int c, b;
    reg_wr(RKC_OFF_CTRL, n);
    jumper <= jmp;
    t_key(2'd1, 4'h3, RKC_MODE_RST);
    @(posedge ref_clk);
    rxCmd <= 2'd1;
    repeat (6) @(posedge ref_clk);
    rxCmd <= 2'd0;
    wait_end(c);
    chk("hangLen", c >= n * HT + 2 && c <= n * HT + 8, 1);
    chk("burstSeen", noiseBurst, !jmp);
    chk("keyInBurst", txCtl.key, !jmp);
    b = 0;
    while (noiseBurst === 1'b1 && b < 50) begin
      @(posedge ref_clk);
      #1 b++;
    end
    chk("burstLen", b, jmp ? 0 : BT);
    @(posedge ref_clk);
    #1 chk("keyAfter", txCtl.key, 0);
  endtask

  // ============================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    jumper = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    rxCmd = 2'd0;
    chanPins = 4'h0;
    regAddr = '0;
    regWrData = '0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1 chk("outs", {txCtl, lampBankA, lampBankB, noiseBurst}, 0);
    reg_rd(RKC_OFF_CTRL, rdv);
    chk("ctrlRst", rdv, 0);
    reg_rd(RKC_OFF_MODE, rdv);
    chk("modeRst", rdv, RKC_MODE_RST);
    reg_rd(4'hc, rdv);
    chk("unmapped", rdv, 0);
    t_key(2'd1, 4'h0, RKC_MODE_RST);
    t_key(2'd2, 4'h0, RKC_MODE_RST);
    reg_wr(RKC_OFF_MODE, 32'h80000002);
    reg_rd(RKC_OFF_MODE, rdv);
    chk("modeWr", rdv, 32'h80000002);
    t_key(2'd1, 4'h1, 32'h80000002);
    t_key(2'd2, 4'hf, 32'h80000002);
    t_key(2'd3, 4'h1, 32'h80000002);
    reg_wr(RKC_OFF_MODE, RKC_MODE_RST);
    t_hang(1, 1'b0);
    t_hang(15, 1'b1);
    t_hang(0, 1'b0);
    finish_test();
  end
endmodule
